// [hw/scdc_pkg.sv]
// Shared constants and types for the system clock domain control block.
// Assumes a single pclk domain at 10 MHz and an APB register port.
`default_nettype none
package scdc_pkg;
  // ==========================================================================
  // Register map (byte addresses, one word each)
  // ==========================================================================
  localparam logic [11:0] SCDC_CGC1_ADDR  = 12'h000; // clock_generator_control_1
  localparam logic [11:0] SCDC_CCFG2_ADDR = 12'h004; // clock_configuration_2
  localparam logic [11:0] SCDC_PCG1_ADDR  = 12'h008; // peripheral_clock_gating_1
  localparam logic [11:0] SCDC_IDLE_ADDR  = 12'h00C; // cpu_idle_configuration
  localparam logic [11:0] SCDC_ST3_ADDR   = 12'h010; // cpu_status_register_3
  localparam logic [11:0] SCDC_USB_ADDR   = 12'h014; // usb_system_control
  localparam logic [11:0] SCDC_STAT_ADDR  = 12'h018; // live status, read only
  localparam logic [11:0] SCDC_RTC_LO     = 12'h900; // rtc window start
  localparam logic [11:0] SCDC_RTC_HI     = 12'h97F; // rtc window end
  localparam logic [11:0] SCDC_RTC_PMGT   = 12'h904; // rtc_power_management
  // ==========================================================================
  // Field positions and widths
  // ==========================================================================
  localparam int SCDC_PLL_POWER_DOWN_BIT_BIT = 0;  // pll_power_down_bit
  localparam int SCDC_SYSSEL_BIT    = 0;  // system_clock_source_select
  localparam int SCDC_MCD_BIT       = 15; // master_clock_disable
  localparam int SCDC_ND            = 8;  // gated peripheral domains
  localparam int SCDC_ICR_BIT       = 0;  // cpu_idle_clock_request
  localparam int SCDC_CLOCK_OUTPUT_DISABLE_BIT    = 0;  // clock_output_disable
  localparam int SCDC_USBEN_BIT     = 0;  // usb oscillator enable
  localparam int SCDC_NIRQ          = 8;  // cpu interrupt lines
  // ==========================================================================
  // Reset values and timing
  // ==========================================================================
  localparam logic [31:0] SCDC_CGC1_RST   = 32'h0000_0000;
  localparam logic [31:0] SCDC_PCG1_RST   = 32'h0000_0000;
  localparam logic [31:0] SCDC_ZERO       = 32'h0000_0000;
  localparam int          SCDC_CLK_NS     = 100;
  localparam int          SCDC_IO_LAT_CYC = 2;  // write latency in cpu cycles
  localparam int          SCDC_IO_LAT_NS  = SCDC_IO_LAT_CYC * SCDC_CLK_NS;
  localparam int          SCDC_LAT_N      = (SCDC_IO_LAT_NS + SCDC_CLK_NS - 1) / SCDC_CLK_NS;
  typedef enum logic [1:0] {
    SCDC_RUN   = 2'b00,
    SCDC_IDLE  = 2'b01,
    SCDC_MSTOP = 2'b10
  } scdc_pwr_t;
endpackage : scdc_pkg
`default_nettype wire

// [hw/scdc_if.sv]
// Interface joining the clock control device and the partner domain logic.
// Assumes both ends share pclk; the bench resolves the debug pin level.
`default_nettype none
interface scdc_if (
  input wire logic pclk,
  input wire logic presetn
);
  logic                       clk_sel;      // Reference select strap.
  logic                       sys_clk_en;   // System clock running.
  logic                       cpu_clk_en;   // CPU clock running.
  logic [scdc_pkg::SCDC_ND-1:0] dom_en;     // Per-domain enables.
  logic                       pll_sel;      // PLL is the system source.
  logic                       idle_instr;   // CPU executed idle.
  logic [scdc_pkg::SCDC_NIRQ-1:0] irq;      // Interrupt requests.
  logic [scdc_pkg::SCDC_NIRQ-1:0] irq_mask; // Interrupt enables.
  logic                       wake_pin;
  logic                       external_interrupt_zero;
  logic                       external_interrupt_one;
  logic                       rtc_irq;
  logic                       dbg_o;        // Debug clock output value.
  logic                       dbg_oe_n;     // Low while driving.
  modport dev (
    input  clk_sel, idle_instr, irq, irq_mask, wake_pin,
           external_interrupt_zero, external_interrupt_one, rtc_irq,
    output sys_clk_en, cpu_clk_en, dom_en, pll_sel, dbg_o, dbg_oe_n
  );
  modport part (
    output clk_sel, idle_instr, irq, irq_mask, wake_pin,
           external_interrupt_zero, external_interrupt_one, rtc_irq,
    input  sys_clk_en, cpu_clk_en, dom_en, pll_sel, dbg_o, dbg_oe_n
  );
endinterface : scdc_if
`default_nettype wire

// [hw/scdc_dev.sv]
// Clock control device: reference select, PLL bypass and power-down, master
// and idle gates, per-domain gates, debug clock pin, APB register port.
// Assumes partner pins arrive asynchronously and are synchronised here.
// Operation
// - Reference from external clock or RTC oscillator
// - Reference-select pin held static by board
// - Bypass lets reference drive system clock
// - USB oscillator never feeds reference path
// - USB oscillator off at reset
// - RTC window dead while RTC oscillator off
// - PLL power-down bit stops the PLL
// - Software bypasses before powering PLL down
// - PLL select refused while PLL down
// - Master disable stops the system clock
// - Wake, external interrupts or RTC restart it (RTC restarts it only while RTC oscillator on)
// - Idle request plus idle instruction stops CPU
// - Unmasked interrupt restarts the CPU clock
// - Each domain has its own enable
// - Clock-output disable tristates debug clock pin
// - Separate 64K-word word-access register space
// - Writes take effect two cycles later
// - Wait latency only after last write
// - Software checks domain enabled before access
// - Gated read returns last value seen
// - Glitch-free switch between bypass and PLL
//
// Our own choices: the APB slave port and the register offsets.
`default_nettype none
module scdc_dev
  import scdc_pkg::*;
(
  input  wire logic        pclk,          // Register clock.
  input  wire logic        presetn,       // Async reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction.
  input  wire logic [15:0] paddr,         // APB word address space.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error.
  input  wire logic        rtc_osc_on,    // RTC oscillator running.
  output logic             usb_osc_en,    // USB oscillator enable.
  output logic             ref_is_rtc,    // Reference from RTC oscillator.
  scdc_if.dev              lnk            // Partner side.
);
  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  localparam int NS = 5 + SCDC_NIRQ;
  logic [NS-1:0] s1_q, s2_q, a_in;
  assign a_in = {lnk.clk_sel, lnk.idle_instr, lnk.wake_pin,
                 lnk.external_interrupt_zero | lnk.external_interrupt_one, lnk.rtc_irq,
                 lnk.irq & lnk.irq_mask};
  logic rtc_s1_q, rtc_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q     <= '0;
      s2_q     <= '0;
      rtc_s1_q <= 1'b0;
      rtc_s2_q <= 1'b0;
    end else begin
      s1_q     <= a_in;
      s2_q     <= s1_q;
      rtc_s1_q <= rtc_osc_on;
      rtc_s2_q <= rtc_s1_q;
    end
  end
  logic sel_s, idle_s, wake_s, xint_s, rtci_s;
  logic [SCDC_NIRQ-1:0] irq_s;
  assign {sel_s, idle_s, wake_s, xint_s, rtci_s, irq_s} = s2_q;
  // Strap caught once after reset release; later changes are ignored.
  logic [2:0] strap_q;
  logic       ref_rtc_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q   <= '0;
      ref_rtc_q <= 1'b0;
    end else begin
      strap_q <= {strap_q[1:0], 1'b1};
      if (strap_q == 3'b011) begin
        ref_rtc_q <= sel_s;
      end
    end
  end
  assign ref_is_rtc = ref_rtc_q;
  // ==========================================================================
  // Registers
  // ==========================================================================
  logic pll_pd_q, syssel_q, mcd_q, icr_q, clock_output_disable_q, usb_en_q;
  logic [SCDC_ND-1:0] dgate_q;     // 1 = domain clock gated off
  logic [15:0]        rtc_pmgt_q;
  logic [31:0]        rtc_last_q;
  logic wr, rd, rtc_hit;
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign rtc_hit = (paddr[11:0] >= SCDC_RTC_LO) && (paddr[11:0] <= SCDC_RTC_HI)
                   && (paddr[15:12] == 4'h1);
  // Writes are staged and applied a fixed latency later.
  logic [SCDC_LAT_N-1:0] wv_q;
  logic [15:0]           wa_q [SCDC_LAT_N];
  logic [31:0]           wd_q [SCDC_LAT_N];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wv_q <= '0;
      for (int i = 0; i < SCDC_LAT_N; i++) begin
        wa_q[i] <= '0;
        wd_q[i] <= SCDC_ZERO;
      end
    end else begin
      wv_q[0] <= wr;
      wa_q[0] <= paddr;
      wd_q[0] <= pwdata;
      for (int i = 1; i < SCDC_LAT_N; i++) begin
        wv_q[i] <= wv_q[i-1];
        wa_q[i] <= wa_q[i-1];
        wd_q[i] <= wd_q[i-1];
      end
    end
  end
  logic        aw;
  logic [15:0] aa;
  logic [31:0] ad;
  assign aw = wv_q[SCDC_LAT_N-1];
  assign aa = wa_q[SCDC_LAT_N-1];
  assign ad = wd_q[SCDC_LAT_N-1];
  logic pwr_wake;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_pd_q <= SCDC_CGC1_RST[SCDC_PLL_POWER_DOWN_BIT_BIT];
      syssel_q <= 1'b0;
      mcd_q    <= SCDC_PCG1_RST[SCDC_MCD_BIT];
      dgate_q  <= SCDC_PCG1_RST[SCDC_ND-1:0];
      icr_q    <= 1'b0;
      clock_output_disable_q <= 1'b0;
      usb_en_q <= 1'b0;
      rtc_pmgt_q <= '0;
    end else begin
      if (pwr_wake) begin
        mcd_q <= 1'b0;
      end
      if (aw) begin
        if (aa == {4'h0, SCDC_CGC1_ADDR}) begin
          pll_pd_q <= ad[SCDC_PLL_POWER_DOWN_BIT_BIT];
        end else if (aa == {4'h0, SCDC_CCFG2_ADDR}) begin
          syssel_q <= ad[SCDC_SYSSEL_BIT] & ~pll_pd_q;
        end else if (aa == {4'h0, SCDC_PCG1_ADDR}) begin
          mcd_q   <= ad[SCDC_MCD_BIT] & ~pwr_wake;
          dgate_q <= ad[SCDC_ND-1:0];
        end else if (aa == {4'h0, SCDC_IDLE_ADDR}) begin
          icr_q <= ad[SCDC_ICR_BIT];
        end else if (aa == {4'h0, SCDC_ST3_ADDR}) begin
          clock_output_disable_q <= ad[SCDC_CLOCK_OUTPUT_DISABLE_BIT];
        end else if (aa == {4'h0, SCDC_USB_ADDR}) begin
          usb_en_q <= ad[SCDC_USBEN_BIT];
        end else if (aa == {4'h1, SCDC_RTC_PMGT} && rtc_s2_q) begin
          rtc_pmgt_q <= ad[15:0];
        end
      end
    end
  end
  assign usb_osc_en = usb_en_q;
  // ==========================================================================
  // Power state: master stop and CPU idle
  // ==========================================================================
  scdc_pwr_t st_q;
  assign pwr_wake = wake_s | xint_s | (rtci_s & rtc_s2_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SCDC_RUN;
    end else begin
      case (st_q)
        SCDC_RUN: begin
          if (mcd_q) begin
            st_q <= SCDC_MSTOP;
          end else if (icr_q && idle_s && (irq_s == '0)) begin
            st_q <= SCDC_IDLE;
          end
        end
        SCDC_IDLE: begin
          if (irq_s != '0) begin
            st_q <= SCDC_RUN;
          end
        end
        SCDC_MSTOP: begin
          if (pwr_wake) begin
            st_q <= SCDC_RUN;
          end
        end
        default: st_q <= SCDC_RUN;
      endcase
    end
  end
  // Enables change on the rising edge, i.e. while the gated clock's latch
  // is closed; the gate cells downstream latch them while the clock is low.
  logic sys_en_q, cpu_en_q, psel_q;
  logic [SCDC_ND-1:0] den_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_en_q <= 1'b1;
      cpu_en_q <= 1'b1;
      den_q    <= '1;
      psel_q   <= 1'b0;
    end else begin
      sys_en_q <= (st_q != SCDC_MSTOP);
      cpu_en_q <= (st_q == SCDC_RUN);
      den_q    <= ~dgate_q & {SCDC_ND{st_q != SCDC_MSTOP}};
      psel_q   <= syssel_q & ~pll_pd_q;
    end
  end
  assign lnk.sys_clk_en = sys_en_q;
  assign lnk.cpu_clk_en = cpu_en_q;
  assign lnk.dom_en     = den_q;
  assign lnk.pll_sel    = psel_q;
  assign lnk.dbg_o      = sys_en_q;
  assign lnk.dbg_oe_n   = clock_output_disable_q;
  // ==========================================================================
  // APB read path
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_last_q <= SCDC_ZERO;
    end else if (rd && rtc_hit && rtc_s2_q) begin
      rtc_last_q <= {16'h0000, rtc_pmgt_q};
    end
  end
  always_comb begin
    prdata  = SCDC_ZERO;
    pslverr = 1'b0;
    if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_CGC1_ADDR) begin
      prdata[SCDC_PLL_POWER_DOWN_BIT_BIT] = pll_pd_q;
    end else if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_CCFG2_ADDR) begin
      prdata[SCDC_SYSSEL_BIT] = syssel_q;
    end else if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_PCG1_ADDR) begin
      prdata[SCDC_MCD_BIT]    = mcd_q;
      prdata[SCDC_ND-1:0]     = dgate_q;
    end else if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_IDLE_ADDR) begin
      prdata[SCDC_ICR_BIT] = icr_q;
    end else if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_ST3_ADDR) begin
      prdata[SCDC_CLOCK_OUTPUT_DISABLE_BIT] = clock_output_disable_q;
    end else if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_USB_ADDR) begin
      prdata[SCDC_USBEN_BIT] = usb_en_q;
    end else if (paddr[15:12] == 4'h0 && paddr[11:0] == SCDC_STAT_ADDR) begin
      prdata[1:0] = st_q;
      prdata[2]   = psel_q;
      prdata[3]   = ref_rtc_q;
      prdata[4]   = rtc_s2_q;
    end else if (rtc_hit) begin
      prdata  = rtc_s2_q ? {16'h0000, rtc_pmgt_q} : rtc_last_q;
      pslverr = ~rtc_s2_q;
    end else begin
      pslverr = 1'b1;
    end
  end
  assign pready = 1'b1;
endmodule : scdc_dev
`default_nettype wire

// [hw/scdc_part.sv]
// Partner end: CPU core and peripheral domain logic facing the clock block.
// Assumes a user port that asks for idle and raises interrupts.
`default_nettype none
module scdc_part
  import scdc_pkg::*;
(
  input  wire logic                 pclk,       // Clock.
  input  wire logic                 presetn,    // Async reset, active low.
  input  wire logic                 strap_rtc,  // Board strap level.
  input  wire logic                 go_idle,    // Request to execute idle.
  input  wire logic [SCDC_NIRQ-1:0] irq_req,    // Interrupt sources.
  input  wire logic [SCDC_NIRQ-1:0] irq_en,     // Interrupt enables.
  input  wire logic                 wake,       // Wake pin level.
  input  wire logic                 ext0,       // External interrupt zero.
  input  wire logic                 ext1,       // External interrupt one.
  input  wire logic                 rtc_int,    // RTC interrupt.
  output logic                      cpu_running,// CPU clock seen running.
  output logic [SCDC_ND-1:0]        dom_running,// Domain clocks running.
  scdc_if.part                      lnk         // Device side.
);
  // ==========================================================================
  // Drive the idle pin from a flip-flop, the other pins straight from inputs; the strap is held static.
  // ==========================================================================
  logic idle_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= go_idle & lnk.cpu_clk_en;
    end
  end
  assign lnk.clk_sel                 = strap_rtc;
  assign lnk.idle_instr              = idle_q;
  assign lnk.irq                     = irq_req;
  assign lnk.irq_mask                = irq_en;
  assign lnk.wake_pin                = wake;
  assign lnk.external_interrupt_zero = ext0;
  assign lnk.external_interrupt_one  = ext1;
  assign lnk.rtc_irq                 = rtc_int;
  // Device status is seen through two flops (another block's timing).
  logic [SCDC_ND:0] m1_q, m2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m1_q <= '0;
      m2_q <= '0;
    end else begin
      m1_q <= {lnk.cpu_clk_en, lnk.dom_en};
      m2_q <= m1_q;
    end
  end
  assign cpu_running = m2_q[SCDC_ND];
  assign dom_running = m2_q[SCDC_ND-1:0];
endmodule : scdc_part
`default_nettype wire

// [testbench/scdc_monitor.sv]
// Checker watching the link between the clock control device and its partner.
// Assumes one pclk domain; the bench top instantiates it beside the link.
`default_nettype none
module scdc_monitor (
  input wire logic                           pclk,                    // Clock.
  input wire logic                           presetn,                 // Reset, low.
  input wire logic                           clk_sel,                 // Strap.
  input wire logic                           sys_clk_en,              // System clock.
  input wire logic                           cpu_clk_en,              // CPU clock.
  input wire logic [scdc_pkg::SCDC_ND-1:0]   dom_en,                  // Domains.
  input wire logic                           pll_sel,                 // PLL source.
  input wire logic                           idle_instr,              // Idle seen.
  input wire logic [scdc_pkg::SCDC_NIRQ-1:0] irq,                     // Requests.
  input wire logic [scdc_pkg::SCDC_NIRQ-1:0] irq_mask,                // Enables.
  input wire logic                           wake_pin,                // Wake.
  input wire logic                           external_interrupt_zero, // Ext 0.
  input wire logic                           external_interrupt_one,  // Ext 1.
  input wire logic                           rtc_irq,                 // RTC event.
  input wire logic                           dbg_o,                   // Debug value.
  input wire logic                           dbg_oe_n                 // Low drives.
);
  import scdc_pkg::*;
  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic       wake_any;
  logic       irq_hit;
  logic [3:0] since_idle_q;
  assign wake_any = wake_pin | external_interrupt_zero | external_interrupt_one | rtc_irq;
  assign irq_hit  = |(irq & irq_mask);
  // Saturating age of the last idle instruction, to bound a CPU clock stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_idle_q <= 4'hF;
    else if (idle_instr) since_idle_q <= 4'h0;
    else if (since_idle_q != 4'hF) since_idle_q <= since_idle_q + 4'h1;
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_reset_state;
    $rose(presetn) |-> sys_clk_en && cpu_clk_en && !pll_sel && !dbg_oe_n && (&dom_en);
  endproperty
  property p_strap_static; $stable(clk_sel); endproperty
  property p_dbg_view; !dbg_oe_n |-> dbg_o == sys_clk_en; endproperty
  property p_mstop_hold; (!sys_clk_en && !wake_any) [*6] |=> !sys_clk_en; endproperty
  property p_mstop_wake;
    !sys_clk_en && $rose(wake_pin | external_interrupt_zero | external_interrupt_one)
      |-> ##[1:6] sys_clk_en;
  endproperty
  property p_idle_cause; $fell(cpu_clk_en) && sys_clk_en |-> since_idle_q <= 4'h6; endproperty
  property p_irq_wake; $rose(irq_hit) && !cpu_clk_en && sys_clk_en |-> ##[1:6] cpu_clk_en;
  endproperty
  property p_irq_keeps; (irq_hit && sys_clk_en) [*6] |-> cpu_clk_en; endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad link state after reset");
  a_strap_static: assert property (p_strap_static) else $error("strap level moved");
  a_dbg_view: assert property (p_dbg_view) else $error("debug pin value wrong");
  a_mstop_hold: assert property (p_mstop_hold) else $error("clock restarted unasked");
  a_mstop_wake: assert property (p_mstop_wake) else $error("wake did not restart");
  a_idle_cause: assert property (p_idle_cause) else $error("cpu stop without idle");
  a_irq_wake: assert property (p_irq_wake) else $error("irq did not restart cpu");
  a_irq_keeps: assert property (p_irq_keeps) else $error("cpu stopped with irq");
  c_idle: cover property ($fell(cpu_clk_en));
  c_mstop: cover property ($fell(sys_clk_en));
  c_wake: cover property ($rose(sys_clk_en));
endmodule : scdc_monitor
`default_nettype wire

// [testbench/test_scdc.sv]
// Bench top: device and partner joined by the link, an APB master, scenarios.
// Assumes the hw files are compiled first.
`default_nettype none
module test_scdc;
  timeunit 1ns;
  timeprecision 1ns;
  import scdc_pkg::*;
  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        rtc_osc_on, usb_osc_en, ref_is_rtc, strap_rtc, go_idle, cpu_running;
  logic        wake, ext0, ext1, rtc_int;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  irq_req, irq_en, dom_running;
  int          err_total, n_checks, k;
  wire logic   dbg_pin;
  scdc_if i_scdc_if (.pclk(pclk), .presetn(presetn));
  assign dbg_pin = i_scdc_if.dbg_oe_n ? 1'bz : i_scdc_if.dbg_o;
  scdc_dev i_scdc_dev (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_osc_on(rtc_osc_on), .usb_osc_en(usb_osc_en),
    .ref_is_rtc(ref_is_rtc), .lnk(i_scdc_if));
  scdc_part i_scdc_part (.pclk(pclk), .presetn(presetn), .strap_rtc(strap_rtc),
    .go_idle(go_idle), .irq_req(irq_req), .irq_en(irq_en), .wake(wake), .ext0(ext0),
    .ext1(ext1), .rtc_int(rtc_int), .cpu_running(cpu_running),
    .dom_running(dom_running), .lnk(i_scdc_if));
  scdc_monitor i_scdc_monitor (.pclk(pclk), .presetn(presetn),
    .clk_sel(i_scdc_if.clk_sel), .sys_clk_en(i_scdc_if.sys_clk_en),
    .cpu_clk_en(i_scdc_if.cpu_clk_en), .dom_en(i_scdc_if.dom_en),
    .pll_sel(i_scdc_if.pll_sel), .idle_instr(i_scdc_if.idle_instr), .irq(i_scdc_if.irq),
    .irq_mask(i_scdc_if.irq_mask), .wake_pin(i_scdc_if.wake_pin),
    .external_interrupt_zero(i_scdc_if.external_interrupt_zero),
    .external_interrupt_one(i_scdc_if.external_interrupt_one),
    .rtc_irq(i_scdc_if.rtc_irq), .dbg_o(i_scdc_if.dbg_o), .dbg_oe_n(i_scdc_if.dbg_oe_n));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset_usb();
    chk("usb_osc_en", 32'h0, {31'h0, usb_osc_en});
    apb(1'b0, {4'h0, SCDC_STAT_ADDR}, SCDC_ZERO);
    chk("status", 32'h8, rd & 32'h0000_000F);
    apb(1'b1, {4'h0, SCDC_USB_ADDR}, 32'h0000_0001);
    @(posedge pclk);
    @(negedge pclk);
    chk("usb early", 32'h0, {31'h0, usb_osc_en});
    cyc(3);
    chk("usb on", 32'h1, {31'h0, usb_osc_en});
    chk("ref_is_rtc", 32'h1, {31'h0, ref_is_rtc});
    apb(1'b1, {4'h0, SCDC_ST3_ADDR}, 32'h0000_0001);
    cyc(4);
    chk("debug pin", 32'h0000_000z, {31'h0, dbg_pin});
    apb(1'b1, {4'h0, SCDC_ST3_ADDR}, SCDC_ZERO);
    cyc(4);
    chk("debug drive", 32'h0, {31'h0, i_scdc_if.dbg_oe_n});
    chk("debug val", 32'h1, {31'h0, dbg_pin});
    $display("test reset and usb done");
  endtask : t_reset_usb
  task automatic t_pll();
    apb(1'b1, {4'h0, SCDC_CCFG2_ADDR}, 32'h0000_0001);
    cyc(4);
    chk("pll on", 32'h1, {31'h0, i_scdc_if.pll_sel});
    apb(1'b1, {4'h0, SCDC_CCFG2_ADDR}, SCDC_ZERO);
    apb(1'b1, {4'h0, SCDC_CGC1_ADDR}, 32'h0000_0001);
    apb(1'b1, {4'h0, SCDC_CCFG2_ADDR}, 32'h0000_0001);
    cyc(4);
    chk("pll refused", 32'h0, {31'h0, i_scdc_if.pll_sel});
    apb(1'b0, {4'h0, SCDC_CGC1_ADDR}, SCDC_ZERO);
    chk("pll down", 32'h1, rd & 32'h0000_0001);
    apb(1'b1, {4'h0, SCDC_CGC1_ADDR}, SCDC_ZERO);
    apb(1'b1, {4'h0, SCDC_CCFG2_ADDR}, 32'h0000_0001);
    cyc(4);
    chk("pll back", 32'h1, {31'h0, i_scdc_if.pll_sel});
    apb(1'b1, {4'h0, SCDC_CCFG2_ADDR}, SCDC_ZERO);
    apb(1'b1, {4'h0, SCDC_PCG1_ADDR}, 32'h0000_00A5);
    cyc(6);
    chk("domains", 32'h5A, {24'h0, i_scdc_if.dom_en});
    chk("domains seen", 32'h5A, {24'h0, dom_running});
    apb(1'b1, {4'h0, SCDC_PCG1_ADDR}, SCDC_ZERO);
    cyc(6);
    chk("domains on", 32'hFF, {24'h0, i_scdc_if.dom_en});
    $display("test pll and domains done");
  endtask : t_pll
  task automatic t_mstop();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, {4'h0, SCDC_PCG1_ADDR}, 32'h0000_8000);
      for (k = 0; k < 10 && i_scdc_if.sys_clk_en !== 1'b0; k++) cyc(1);
      cyc(8);
      chk("stopped", 32'h0, {31'h0, i_scdc_if.sys_clk_en});
      wake    <= (i == 0);
      ext0    <= (i == 1);
      ext1    <= (i == 2);
      rtc_int <= (i == 3);
      for (k = 0; k < 10 && i_scdc_if.sys_clk_en !== 1'b1; k++) cyc(1);
      chk("restarted", 32'h1, {31'h0, i_scdc_if.sys_clk_en});
      {wake, ext0, ext1, rtc_int} <= 4'h0;
      apb(1'b0, {4'h0, SCDC_PCG1_ADDR}, SCDC_ZERO);
      chk("master bit", 32'h0, rd & 32'h0000_8000);
    end
    $display("test master stop done");
  endtask : t_mstop
  task automatic t_idle();
    irq_en  <= 8'h01;
    go_idle <= 1'b1;
    cyc(10);
    chk("no request", 32'h1, {31'h0, i_scdc_if.cpu_clk_en});
    apb(1'b1, {4'h0, SCDC_IDLE_ADDR}, 32'h0000_0001);
    for (k = 0; k < 12 && i_scdc_if.cpu_clk_en !== 1'b0; k++) cyc(1);
    chk("idle", 32'h0, {31'h0, i_scdc_if.cpu_clk_en});
    irq_req <= 8'h02;
    cyc(10);
    chk("masked", 32'h0, {31'h0, i_scdc_if.cpu_clk_en});
    chk("cpu seen", 32'h0, {31'h0, cpu_running});
    irq_req <= 8'h01;
    for (k = 0; k < 10 && i_scdc_if.cpu_clk_en !== 1'b1; k++) cyc(1);
    chk("woken", 32'h1, {31'h0, i_scdc_if.cpu_clk_en});
    go_idle <= 1'b0;
    cyc(4);
    irq_req <= 8'h00;
    apb(1'b1, {4'h0, SCDC_IDLE_ADDR}, SCDC_ZERO);
    $display("test idle done");
  endtask : t_idle
  task automatic t_rtc();
    apb(1'b1, 16'h1904, 32'h0000_1234);
    apb(1'b0, 16'h1904, SCDC_ZERO);
    chk("rtc read", 32'h1234, rd & 32'h0000_FFFF);
    rtc_osc_on <= 1'b0;
    cyc(4);
    apb(1'b1, 16'h1904, 32'h0000_5555);
    chk("rtc write err", 32'h1, {31'h0, er});
    apb(1'b0, 16'h1904, SCDC_ZERO);
    chk("rtc read err", 32'h1, {31'h0, er});
    chk("rtc stale", 32'h1234, rd & 32'h0000_FFFF);
    apb(1'b0, 16'h0100, SCDC_ZERO);
    chk("unmapped", 32'h1, {31'h0, er});
    rtc_osc_on <= 1'b1;
    cyc(4);
    apb(1'b0, 16'h1904, SCDC_ZERO);
    chk("rtc kept", 32'h1234, rd & 32'h0000_FFFF);
    $display("test rtc window done");
  endtask : t_rtc
  // ==========================================================================
  // Clock, watchdog and main sequence
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    cyc(20000);
    err_total++;
    test_done();
  end
  initial begin
    {presetn, psel, penable, pwrite, go_idle, wake, ext0, ext1, rtc_int} = 9'h0;
    {paddr, pwdata, irq_req, irq_en} = 64'h0;
    {strap_rtc, rtc_osc_on} = 2'b11;
    err_total = 0;
    n_checks = 0;
    cyc(5);
    presetn <= 1'b1;
    cyc(4);
    t_reset_usb();
    t_pll();
    t_mstop();
    t_idle();
    t_rtc();
    test_done();
  end
endmodule : test_scdc
`default_nettype wire
